//--- rmsc_top.sv
// radio operating-mode state machine with its ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module rmsc_top #(
   parameter int ARD_STEP_CYC = rmsc_pkg::ARD_STEP_CYC,
   parameter int CD_FILT_CYC = rmsc_pkg::CD_MIN_CYC
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CLK_EN_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic CE_PIN_I,
   input wire logic RF_DETECT_I,
   input wire logic TX_FIFO_EMPTY_I,
   input wire logic RX_FIFO_FULL_I,
   input wire logic PKT_SENT_I,
   input wire logic PKT_NO_ACK_I,
   input wire logic ACK_RCVD_I,
   input wire logic ACK_TIMEOUT_I,
   input wire logic RX_PKT_VALID_I,
   input wire logic RX_PKT_NO_ACK_I,
   output logic [2:0] MODE_O,
   output logic TX_GO_O,
   output logic RX_STORE_O,
   output logic RX_DROP_O,
   output logic CARRIER_DETECT_O,
   output logic IRQ_N_O
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      rmsc_pkg::rmsc_mode_t mode;
      logic ce_s1;
      logic ce_s2;
      logic ce_s3;
      logic ce;
      logic [rmsc_pkg::CE_CNT_W-1:0] ce_cnt;
      logic power_up_bit;
      logic primary_receive_select;
      logic auto_ack_enable;
      logic [3:0] retransmit_limit;
      logic [3:0] retransmit_delay;
      logic [3:0] retry_count;
      logic retry_exhausted_flag;
      logic retry_pend;
      logic wait_ack;
      logic [rmsc_pkg::ARD_CNT_W-1:0] ard_cnt;
      logic ph_act;
      logic ph_wr;
      logic [31:0] ph_addr;
      logic hready;
      logic [31:0] hrdata;
      logic tx_go;
      logic rx_store;
      logic rx_drop;
      logic irq_n;
   } rmsc_state_t;

   rmsc_state_t st_reg;
   rmsc_state_t st_next;
   logic carrier_detect;
   logic ce_long;
   logic [rmsc_pkg::ARD_CNT_W-1:0] ard_last;
   logic [31:0] wdat;

   // mode after a finished packet or a received acknowledge
   function automatic rmsc_pkg::rmsc_mode_t after_packet(input logic ce, input logic empty);
      if (!ce) begin
         return rmsc_pkg::MODE_STBY1;
      end else if (!empty) begin
         return rmsc_pkg::MODE_TX;
      end else begin
         return rmsc_pkg::MODE_STBY2;
      end
   endfunction

   rmsc_cd_filter #(
      .FILT_CYC(CD_FILT_CYC)
   ) rmsc_cd_filter_i (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .clk_en_i(CLK_EN_I),
      .rf_raw_i(RF_DETECT_I),
      .rx_active_i(st_reg.mode == rmsc_pkg::MODE_RX),
      .cd_o(carrier_detect)
   );

   assign ce_long = st_reg.ce &&
      (st_reg.ce_cnt == rmsc_pkg::CE_CNT_W'(rmsc_pkg::CE_MIN_CYC));
   assign ard_last = rmsc_pkg::ARD_CNT_W'(({16'h0000, st_reg.retransmit_delay} + 20'h00001) *
      ARD_STEP_CYC - 1);
   assign wdat = HWDATA_I;

   always_comb begin
      st_next = st_reg;
      st_next.tx_go = 1'b0;
      st_next.rx_store = 1'b0;
      st_next.rx_drop = 1'b0;

      // ***************************************************************
      // chip-enable pin synchroniser and pulse timer
      // ***************************************************************
      st_next.ce_s1 = CE_PIN_I;
      st_next.ce_s2 = st_reg.ce_s1;
      st_next.ce_s3 = st_reg.ce_s2;
      st_next.ce = rmsc_pkg::rmsc_agree(st_reg.ce, st_reg.ce_s2, st_reg.ce_s3);
      if (!st_reg.ce) begin
         st_next.ce_cnt = '0;
      end else if (!ce_long) begin
         st_next.ce_cnt = st_reg.ce_cnt + 1'b1;
      end

      // ***************************************************************
      // ahb-lite slave, one wait state per transfer
      // ***************************************************************
      // the wait state lets a write land before any following read samples it
      if (st_reg.ph_act) begin
         st_next.ph_act = 1'b0;
         st_next.hready = 1'b1;
         st_next.hrdata = 32'h0000_0000;
         if (st_reg.ph_wr) begin
            if (st_reg.ph_addr == rmsc_pkg::CFG_ADDR) begin
               st_next.power_up_bit = wdat[rmsc_pkg::CFG_PWR_BIT];
               st_next.primary_receive_select = wdat[rmsc_pkg::CFG_PRX_BIT];
               st_next.auto_ack_enable = wdat[rmsc_pkg::CFG_AA_BIT];
               st_next.retransmit_limit = wdat[rmsc_pkg::CFG_ARC_LSB +: 4];
               st_next.retransmit_delay = wdat[rmsc_pkg::CFG_ARD_LSB +: 4];
            end else if (st_reg.ph_addr == rmsc_pkg::STS_ADDR &&
                         wdat[rmsc_pkg::STS_MAXRT_BIT]) begin
               st_next.retry_exhausted_flag = 1'b0;
            end
         end else if (st_reg.ph_addr == rmsc_pkg::CFG_ADDR) begin
            st_next.hrdata[rmsc_pkg::CFG_PWR_BIT] = st_reg.power_up_bit;
            st_next.hrdata[rmsc_pkg::CFG_PRX_BIT] = st_reg.primary_receive_select;
            st_next.hrdata[rmsc_pkg::CFG_AA_BIT] = st_reg.auto_ack_enable;
            st_next.hrdata[rmsc_pkg::CFG_ARC_LSB +: 4] = st_reg.retransmit_limit;
            st_next.hrdata[rmsc_pkg::CFG_ARD_LSB +: 4] = st_reg.retransmit_delay;
         end else if (st_reg.ph_addr == rmsc_pkg::STS_ADDR) begin
            st_next.hrdata[rmsc_pkg::STS_MODE_LSB +: 3] = st_reg.mode;
            st_next.hrdata[rmsc_pkg::STS_RCNT_LSB +: 4] = st_reg.retry_count;
            st_next.hrdata[rmsc_pkg::STS_MAXRT_BIT] = st_reg.retry_exhausted_flag;
            st_next.hrdata[rmsc_pkg::STS_CD_BIT] = carrier_detect;
         end
      end else if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
         st_next.ph_act = 1'b1;
         st_next.ph_wr = HWRITE_I;
         st_next.ph_addr = HADDR_I;
         st_next.hready = 1'b0;
      end

      // ***************************************************************
      // operating mode machine
      // ***************************************************************
      case (st_reg.mode)
         rmsc_pkg::MODE_PWR_DOWN: begin
            if (st_reg.power_up_bit) begin
               st_next.mode = rmsc_pkg::MODE_STBY1;
            end
         end
         rmsc_pkg::MODE_STBY1: begin
            if (st_reg.primary_receive_select) begin
               if (st_reg.ce) begin
                  st_next.mode = rmsc_pkg::MODE_RX;
               end
            end else if (st_reg.retry_pend) begin
               if (!st_reg.auto_ack_enable) begin
                  st_next.retry_pend = 1'b0;
               end else if (st_reg.ard_cnt == ard_last) begin
                  st_next.retry_pend = 1'b0;
                  st_next.retry_count = st_reg.retry_count + 1'b1;
                  st_next.mode = rmsc_pkg::MODE_TX;
                  st_next.tx_go = 1'b1;
               end else begin
                  st_next.ard_cnt = st_reg.ard_cnt + 1'b1;
               end
            end else if (ce_long && !TX_FIFO_EMPTY_I) begin
               // qualified pulse with payload starts transmit
               st_next.mode = rmsc_pkg::MODE_TX;
               st_next.tx_go = 1'b1;
               st_next.retry_count = 4'h0;
            end else if (st_reg.ce && TX_FIFO_EMPTY_I) begin
               st_next.mode = rmsc_pkg::MODE_STBY2;
            end
         end
         rmsc_pkg::MODE_STBY2: begin
            // chip-enable low or role change leaves standby-II
            if (!st_reg.ce || st_reg.primary_receive_select) begin
               st_next.mode = rmsc_pkg::MODE_STBY1;
            end else if (!TX_FIFO_EMPTY_I) begin
               // new payload sends on its own
               st_next.mode = rmsc_pkg::MODE_TX;
               st_next.tx_go = 1'b1;
               st_next.retry_count = 4'h0;
            end
         end
         rmsc_pkg::MODE_TX: begin
            // hold transmit until the packet is out
            if (PKT_SENT_I) begin
               if (st_reg.primary_receive_select) begin
                  st_next.mode = st_reg.ce ? rmsc_pkg::MODE_RX : rmsc_pkg::MODE_STBY1;
               end else if (st_reg.auto_ack_enable && !PKT_NO_ACK_I) begin
                  // wait for the acknowledge in receive
                  st_next.mode = rmsc_pkg::MODE_RX;
                  st_next.wait_ack = 1'b1;
               end else if (st_reg.auto_ack_enable) begin
                  st_next.mode = rmsc_pkg::MODE_STBY1;
               end else begin
                  st_next.mode = after_packet(st_reg.ce, TX_FIFO_EMPTY_I);
                  st_next.tx_go = (st_next.mode == rmsc_pkg::MODE_TX);
                  st_next.retry_count = 4'h0;
               end
            end
         end
         rmsc_pkg::MODE_RX: begin
            if (st_reg.wait_ack) begin
               // a pending acknowledge keeps receive even with chip-enable low
               if (ACK_RCVD_I) begin
                  st_next.wait_ack = 1'b0;
                  st_next.mode = after_packet(st_reg.ce, TX_FIFO_EMPTY_I);
                  st_next.tx_go = (st_next.mode == rmsc_pkg::MODE_TX);
                  st_next.retry_count = 4'h0;
               end else if (ACK_TIMEOUT_I) begin
                  st_next.wait_ack = 1'b0;
                  st_next.mode = rmsc_pkg::MODE_STBY1;
                  // retry or give up past the limit
                  if (st_reg.retry_count < st_reg.retransmit_limit) begin
                     st_next.retry_pend = 1'b1;
                     st_next.ard_cnt = '0;
                  end else begin
                     st_next.retry_exhausted_flag = 1'b1;
                  end
               end
            end else if (!st_reg.ce || !st_reg.primary_receive_select) begin
               st_next.mode = rmsc_pkg::MODE_STBY1;
            end else if (RX_PKT_VALID_I) begin
               if (RX_FIFO_FULL_I) begin
                  st_next.rx_drop = 1'b1;
               end else begin
                  st_next.rx_store = 1'b1;
                  if (st_reg.auto_ack_enable && !RX_PKT_NO_ACK_I) begin
                     st_next.mode = rmsc_pkg::MODE_TX;
                     st_next.tx_go = 1'b1;
                  end
               end
            end
         end
         default: begin
            st_next.mode = rmsc_pkg::MODE_PWR_DOWN;
         end
      endcase

      // without auto-ack nothing waits or retries
      if (!st_reg.auto_ack_enable && st_reg.wait_ack) begin
         st_next.wait_ack = 1'b0;
         st_next.tx_go = 1'b0;
         st_next.mode = rmsc_pkg::MODE_STBY1;
      end

      if (!st_reg.power_up_bit) begin
         st_next.mode = rmsc_pkg::MODE_PWR_DOWN;
         st_next.wait_ack = 1'b0;
         st_next.retry_pend = 1'b0;
         st_next.tx_go = 1'b0;
      end

      st_next.irq_n = !st_next.retry_exhausted_flag;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_reg <= '0;
         st_reg.mode <= rmsc_pkg::MODE_PWR_DOWN;
         st_reg.power_up_bit <= rmsc_pkg::CFG_RESET[rmsc_pkg::CFG_PWR_BIT];
         st_reg.hready <= 1'b1;
         st_reg.irq_n <= 1'b1;
      end else if (CLK_EN_I) begin
         st_reg <= st_next;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign HRDATA_O = st_reg.hrdata;
   assign HREADYOUT_O = st_reg.hready;
   assign HRESP_O = 1'b0;
   assign MODE_O = st_reg.mode;
   assign TX_GO_O = st_reg.tx_go;
   assign RX_STORE_O = st_reg.rx_store;
   assign RX_DROP_O = st_reg.rx_drop;
   assign CARRIER_DETECT_O = carrier_detect;
   assign IRQ_N_O = st_reg.irq_n;

endmodule

//--- rmsc_pkg.sv
// constants, types and shared helpers of the radio mode state control block
package rmsc_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int CLK_MHZ = 250;
   localparam int CE_MIN_US = 10;
   localparam int CE_MIN_CYC = CE_MIN_US * CLK_MHZ;
   localparam int CE_CNT_W = 12;
   localparam int CD_MIN_US = 128;
   localparam int CD_MIN_CYC = CD_MIN_US * CLK_MHZ;
   localparam int CD_CNT_W = 16;
   localparam int ARD_STEP_US = 250;
   localparam int ARD_STEP_CYC = ARD_STEP_US * CLK_MHZ;
   localparam int ARD_CNT_W = 20;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [31:0] CFG_ADDR = 32'h0000_0000;
   localparam logic [31:0] STS_ADDR = 32'h0000_0004;
   localparam int CFG_PWR_BIT = 0;
   localparam int CFG_PRX_BIT = 1;
   localparam int CFG_AA_BIT = 2;
   localparam int CFG_ARC_LSB = 4;
   localparam int CFG_ARD_LSB = 8;
   localparam int STS_MODE_LSB = 0;
   localparam int STS_RCNT_LSB = 4;
   localparam int STS_MAXRT_BIT = 8;
   localparam int STS_CD_BIT = 9;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // ***************************************************************
   // operating modes
   // ***************************************************************
   typedef enum logic [2:0] {
      MODE_PWR_DOWN,
      MODE_STBY1,
      MODE_STBY2,
      MODE_TX,
      MODE_RX
   } rmsc_mode_t;

   // filtered level of a three-stage synchroniser
   function automatic logic rmsc_agree(input logic held, input logic s2, input logic s3);
      return (s2 == s3) ? s3 : held;
   endfunction

endpackage

//--- rmsc_cd_filter.sv
// carrier detect filter: synchroniser and minimum-presence counter
`timescale 1ns/100ps
module rmsc_cd_filter #(
   parameter int FILT_CYC = rmsc_pkg::CD_MIN_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic rf_raw_i,
   input wire logic rx_active_i,
   output logic cd_o
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic [rmsc_pkg::CD_CNT_W-1:0] cnt;
      logic cd;
   } rmsc_cdf_t;

   rmsc_cdf_t cdf_reg;
   rmsc_cdf_t cdf_next;

   always_comb begin
      cdf_next = cdf_reg;
      cdf_next.s1 = rf_raw_i;
      cdf_next.s2 = cdf_reg.s1;
      cdf_next.s3 = cdf_reg.s2;
      cdf_next.lvl = rmsc_pkg::rmsc_agree(cdf_reg.lvl, cdf_reg.s2, cdf_reg.s3);
      if (!rx_active_i || !cdf_reg.lvl) begin
         cdf_next.cnt = '0;
         cdf_next.cd = 1'b0;
      end else if (cdf_reg.cnt == rmsc_pkg::CD_CNT_W'(FILT_CYC - 1)) begin
         cdf_next.cd = 1'b1;
      end else begin
         cdf_next.cnt = cdf_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cdf_reg <= '0;
      end else if (clk_en_i) begin
         cdf_reg <= cdf_next;
      end
   end

   assign cd_o = cdf_reg.cd;

endmodule

//--- rmsc_top_monitor.sv
// concurrent checker bound to the radio mode state control top
`timescale 1ns/100ps
module rmsc_monitor #(
   parameter int CD_FILT_CYC = 16
) (
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CLK_EN_I,
   input wire logic HSEL_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HREADY_I,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   input wire logic RF_DETECT_I,
   input wire logic RX_FIFO_FULL_I,
   input wire logic ACK_TIMEOUT_I,
   input wire logic RX_PKT_VALID_I,
   input wire logic [2:0] MODE_O,
   input wire logic TX_GO_O,
   input wire logic RX_STORE_O,
   input wire logic RX_DROP_O,
   input wire logic CARRIER_DETECT_O,
   input wire logic IRQ_N_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // raw run length, saturating so a long carrier never wraps
   logic [15:0] rf_run;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rf_run <= 16'h0000;
      end else if (!RF_DETECT_I) begin
         rf_run <= 16'h0000;
      end else if (rf_run != 16'hffff) begin
         rf_run <= rf_run + 16'h0001;
      end
   end
   // ***************************************************************
   // properties
   // ***************************************************************
   property p_rst_idle; $rose(RST_N_I) |-> MODE_O == 3'h0 && IRQ_N_O; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
   property p_bus_take;
      CLK_EN_I && HSEL_I && HTRANS_I[1] && HREADY_I && HREADYOUT_O |=> !HREADYOUT_O ##1 HREADYOUT_O;
   endproperty
   a_bus_take: assert property (p_bus_take) else $error("bus wait state wrong");
   property p_okay; HRESP_O == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("bus response not okay");
   property p_go_tx; TX_GO_O |-> MODE_O == 3'h3; endproperty
   a_go_tx: assert property (p_go_tx) else $error("send start outside transmit");
   property p_go_pulse; TX_GO_O && CLK_EN_I |=> !TX_GO_O; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("send start too long");
   property p_store;
      RX_STORE_O |-> $past(RX_PKT_VALID_I) && !$past(RX_FIFO_FULL_I) && $past(MODE_O) == 3'h4;
   endproperty
   a_store: assert property (p_store) else $error("store without cause");
   property p_drop;
      RX_DROP_O |-> $past(RX_PKT_VALID_I) && $past(RX_FIFO_FULL_I) && !RX_STORE_O;
   endproperty
   a_drop: assert property (p_drop) else $error("drop without full fifo");
   property p_cd;
      $rose(CARRIER_DETECT_O) |-> $past(rf_run, 3) >= CD_FILT_CYC && $past(MODE_O) == 3'h4;
   endproperty
   a_cd: assert property (p_cd) else $error("carrier detect too early");
   property p_irq; $fell(IRQ_N_O) |-> $past(ACK_TIMEOUT_I); endproperty
   a_irq: assert property (p_irq) else $error("interrupt without timeout");
   c_go: cover property (TX_GO_O);
   c_drop: cover property (RX_DROP_O);
   c_irq: cover property ($fell(IRQ_N_O));
   c_cd: cover property ($rose(CARRIER_DETECT_O));
endmodule
bind rmsc_top rmsc_monitor #(.CD_FILT_CYC(CD_FILT_CYC)) rmsc_monitor_i (
   .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CLK_EN_I(CLK_EN_I), .HSEL_I(HSEL_I),
   .HTRANS_I(HTRANS_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
   .RF_DETECT_I(RF_DETECT_I), .RX_FIFO_FULL_I(RX_FIFO_FULL_I), .ACK_TIMEOUT_I(ACK_TIMEOUT_I),
   .RX_PKT_VALID_I(RX_PKT_VALID_I), .MODE_O(MODE_O), .TX_GO_O(TX_GO_O),
   .RX_STORE_O(RX_STORE_O), .RX_DROP_O(RX_DROP_O), .CARRIER_DETECT_O(CARRIER_DETECT_O),
   .IRQ_N_O(IRQ_N_O));

//--- rmsc_pkt_model.sv
// behavioural packet engine and transmit fifo facing the mode control
`timescale 1ns/100ps
module rmsc_pkt_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic tx_go_i,
   input wire logic load_i,
   input wire logic ptx_i,
   input wire logic no_ack_i,
   input wire logic [1:0] ack_kind_i,
   input wire logic [7:0] air_cyc_i,
   output logic tx_empty_o,
   output logic pkt_sent_o,
   output logic pkt_no_ack_o,
   output logic ack_rcvd_o,
   output logic ack_timeout_o
);
   int fill;
   assign tx_empty_o = (fill == 0);
   // payload leaves the fifo on each primary-transmitter start pulse, so a retry pops a second one if one is queued
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fill <= 0;
      end else begin
         fill <= fill + int'(load_i) - int'(tx_go_i && ptx_i && fill > 0);
      end
   end
   initial begin
      {pkt_sent_o, pkt_no_ack_o, ack_rcvd_o, ack_timeout_o} = 4'h0;
      forever begin
         @(posedge clk_i);
         if (tx_go_i === 1'b1) begin
            repeat (air_cyc_i) @(posedge clk_i);
            pkt_sent_o <= 1'b1;
            pkt_no_ack_o <= no_ack_i;
            @(posedge clk_i);
            pkt_sent_o <= 1'b0;
            pkt_no_ack_o <= ~no_ack_i;
            if (ptx_i && !no_ack_i && ack_kind_i != 2'h0) begin
               repeat (air_cyc_i) @(posedge clk_i);
               ack_rcvd_o <= (ack_kind_i == 2'h1);
               ack_timeout_o <= (ack_kind_i == 2'h2);
               @(posedge clk_i);
               ack_rcvd_o <= 1'b0;
               ack_timeout_o <= 1'b0;
            end
         end
      end
   end
endmodule

//--- rmsc_bench.sv
// self-checking bench for the radio mode state control top
`timescale 1ns/100ps
module rmsc_bench;
   logic clk, rst_n, hsel, hwrite, hready, ce, rf, rx_full, rx_valid, rx_na;
   logic load, primary_transmitter, no_ack, tx_empty, sent, sent_na, ack_ok, ack_to;
   logic go, store, drop, cd, irq_n, clk_en;
   logic [1:0] htrans, ack_kind;
   logic [2:0] mode;
   logic [7:0] air;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int bad_count = 0, total_checks = 0, n_go = 0, n_store = 0, n_drop = 0, k, j;
   rmsc_top #(.ARD_STEP_CYC(20), .CD_FILT_CYC(16)) rmsc_top_i (
      .CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(clk_en), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
      .CE_PIN_I(ce), .RF_DETECT_I(rf), .TX_FIFO_EMPTY_I(tx_empty), .RX_FIFO_FULL_I(rx_full),
      .PKT_SENT_I(sent), .PKT_NO_ACK_I(sent_na), .ACK_RCVD_I(ack_ok), .ACK_TIMEOUT_I(ack_to),
      .RX_PKT_VALID_I(rx_valid), .RX_PKT_NO_ACK_I(rx_na), .MODE_O(mode), .TX_GO_O(go),
      .RX_STORE_O(store), .RX_DROP_O(drop), .CARRIER_DETECT_O(cd), .IRQ_N_O(irq_n));
   rmsc_pkt_model rmsc_pkt_model_i (
      .clk_i(clk), .rst_n_i(rst_n), .tx_go_i(go), .load_i(load), .ptx_i(primary_transmitter),
      .no_ack_i(no_ack), .ack_kind_i(ack_kind), .air_cyc_i(air), .tx_empty_o(tx_empty),
      .pkt_sent_o(sent), .pkt_no_ack_o(sent_na), .ack_rcvd_o(ack_ok), .ack_timeout_o(ack_to));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      n_go += int'(go === 1'b1);
      n_store += int'(store === 1'b1);
      n_drop += int'(drop === 1'b1);
   end
   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chk_mode(input logic [2:0] m);
      check({29'h0, mode}, {29'h0, m});
   endtask
   // what: 0 mode equals m, 1 carrier detect high, 2 interrupt low
   task automatic wait_for(input int what, input logic [2:0] m, input int bound);
      int n;
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < bound) begin
         @(posedge clk);
         #1;
         hit = (what == 0) ? (mode === m) : (what == 1) ? (cd === 1'b1) : (irq_n === 1'b0);
         n++;
      end
      check({31'h0, hit}, 32'h1);
      if (!hit) complete_run();
   endtask
   // single word transfer; the wait is bounded, not assumed
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
      check({31'h0, n < 100}, 32'h1);
      if (n >= 100) complete_run();
   endtask
   task automatic pulse_load(input int cnt);
      repeat (cnt) begin
         @(posedge clk);
         load <= 1'b1;
      end
      @(posedge clk);
      load <= 1'b0;
   endtask
   task automatic rx_pkt(input logic na);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_na <= na;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_na <= ~na;
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      {rst_n, hsel, hwrite, ce, rf, rx_full, rx_valid, rx_na, load, no_ack} = 10'h0;
      {htrans, ack_kind, haddr, hwdata} = 68'h0;
      primary_transmitter = 1'b1;
      clk_en = 1'b1;
      air = 8'd8;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk_mode(3'h0);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd, 32'h0);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, 32'h8, 32'hffff_ffff);
      ahb(1'b0, 32'h8, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, 32'h0, 32'h0000_0536);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd, 32'h0000_0536);
      chk_mode(3'h0);
      ahb(1'b1, 32'h0, 32'h0000_0001);
      wait_for(0, 3'h1, 20);
      pulse_load(1);
      ce <= 1'b1;
      // chip-enable still short of the minimum pulse
      repeat (2000) @(posedge clk);
      #1;
      chk_mode(3'h1);
      wait_for(0, 3'h3, 1000);
      wait_for(0, 3'h2, 100);
      // snapshot before the loads, the first start pulse is counted early
      k = n_go;
      pulse_load(2);
      wait_for(0, 3'h3, 20);
      wait_for(0, 3'h2, 200);
      check(32'(n_go - k), 32'h2);
      air <= 8'd60;
      pulse_load(1);
      wait_for(0, 3'h3, 20);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk_mode(3'h3);
      wait_for(0, 3'h1, 100);
      air <= 8'd8;
      ahb(1'b1, 32'h0, 32'h0000_0025);
      ack_kind <= 2'h1;
      pulse_load(1);
      ce <= 1'b1;
      wait_for(0, 3'h3, 3000);
      wait_for(0, 3'h4, 100);
      wait_for(0, 3'h2, 100);
      ack_kind <= 2'h2;
      k = n_go;
      pulse_load(1);
      wait_for(0, 3'h4, 100);
      wait_for(0, 3'h1, 100);
      wait_for(0, 3'h3, 100);
      wait_for(2, 3'h0, 1000);
      check(32'(n_go - k), 32'h3);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd & 32'h0000_03f0, 32'h0000_0120);
      ahb(1'b1, 32'h4, 32'h0000_0100);
      @(posedge clk);
      #1;
      check({31'h0, irq_n}, 32'h1);
      ce <= 1'b0;
      wait_for(0, 3'h1, 200);
      no_ack <= 1'b1;
      ack_kind <= 2'h1;
      pulse_load(1);
      ce <= 1'b1;
      wait_for(0, 3'h3, 3000);
      wait_for(0, 3'h1, 100);
      {ce, no_ack, primary_transmitter} <= 3'h0;
      ahb(1'b1, 32'h0, 32'h0000_0007);
      wait_for(0, 3'h1, 100);
      ce <= 1'b1;
      wait_for(0, 3'h4, 100);
      k = n_store;
      rx_pkt(1'b0);
      wait_for(0, 3'h3, 10);
      wait_for(0, 3'h4, 100);
      rx_full <= 1'b1;
      rx_pkt(1'b0);
      repeat (20) @(posedge clk);
      #1;
      chk_mode(3'h4);
      check(32'(n_drop), 32'h1);
      rx_full <= 1'b0;
      j = n_go;
      rx_pkt(1'b1);
      repeat (20) @(posedge clk);
      #1;
      chk_mode(3'h4);
      check(32'(n_go - j), 32'h0);
      check(32'(n_store - k), 32'h2);
      rf <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check({31'h0, cd}, 32'h0);
      wait_for(1, 3'h0, 100);
      ahb(1'b0, 32'h4, 32'h0);
      check(rd & 32'h0000_0207, 32'h0000_0204);
      rf <= 1'b0;
      repeat (200) @(posedge clk);
      #1;
      chk_mode(3'h4);
      // frozen clock enable: the chip-enable drop must not be seen yet
      clk_en <= 1'b0;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      #1;
      chk_mode(3'h4);
      clk_en <= 1'b1;
      wait_for(0, 3'h1, 20);
      ahb(1'b1, 32'h0, 32'h0000_0006);
      wait_for(0, 3'h0, 20);
      ahb(1'b0, 32'h0, 32'h0);
      check(rd, 32'h0000_0006);
      complete_run();
   end
endmodule
